// ### include/cit_pkg.sv
// Package of the core interrupt controller and tick timer.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz core clock.
package cit_pkg;

	// ************************************************************
	// Register map (byte addresses).
	// ************************************************************
	localparam logic [7:0] TICK_CTRL_OFS    = 8'h00;
	localparam logic [7:0] TICK_RELOAD_OFS  = 8'h04;
	localparam logic [7:0] TICK_CURRENT_OFS = 8'h08;
	localparam logic [7:0] IRQ_SET_EN_OFS   = 8'h10;
	localparam logic [7:0] IRQ_CLR_EN_OFS   = 8'h14;
	localparam logic [7:0] IRQ_SET_PEND_OFS = 8'h18;
	localparam logic [7:0] IRQ_CLR_PEND_OFS = 8'h1C;
	localparam logic [7:0] IRQ_ACTIVE_OFS   = 8'h20;
	localparam logic [7:0] IRQ_PRIO_OFS     = 8'h40;
	localparam logic [7:0] IRQ_PRIO_LAST    = 8'h5C;

	// ************************************************************
	// Field positions and widths.
	// ************************************************************
	localparam int TICK_W          = 24;
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_INT_BIT    = 1;
	localparam int CTRL_FLAG_BIT   = 16;
	localparam int PRIO_FIELD_W    = 8;
	localparam int PRIO_IMPL_W     = 2;
	localparam int PRIO_PER_REG    = 4;
	localparam int EXC_NUM_W       = 6;

	// ************************************************************
	// Reset values and fixed constants.
	// ************************************************************
	localparam logic [31:0]        VECTOR_BASE     = 32'h0000_0000;
	localparam logic [EXC_NUM_W-1:0] IRQ_EXC_BASE  = 6'h10;
	localparam logic [EXC_NUM_W-1:0] TICK_EXC_NUM  = 6'h0F;
	localparam logic [TICK_W-1:0]  TICK_RST        = 24'h00_0000;
	localparam logic [31:0]        ZERO_WORD       = 32'h0000_0000;
	localparam logic [1:0]         RESP_OKAY       = 2'h0;
	localparam logic [1:0]         RESP_SLVERR     = 2'h2;

	// ************************************************************
	// Interrupt request offered to the core.
	// ************************************************************
	typedef struct packed {
		logic                  valid;
		logic [4:0]            irq;
		logic [EXC_NUM_W-1:0]  exc_num;
		logic [PRIO_IMPL_W-1:0] prio;
		logic [31:0]           vector_addr;
	} cit_req_t;

endpackage : cit_pkg

// ### rtl/cit_core.sv
// Interrupt controller with 32 prioritised inputs and a 24-bit tick timer.
// Assumes synchronous inputs, one clock, AXI4-Lite master on the bus side.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// How it works
// RULE1: tick counter is 24 bits, counts down once per tick enable, wraps at zero.
// RULE2: after reaching zero the counter loads the reload value on the next tick.
// RULE3: the wrap flag is set whenever the counter steps down to zero.
// RULE4: reading the tick control word clears the wrap flag.
// RULE5: any write to the current-value register clears the counter to zero.
// RULE6: software clears current value before enabling; counting then starts from reload.
// RULE7: with reload zero the counter stays at zero after reloading.
// RULE8: an accepted interrupt gets its handler address from its vector table entry.
// RULE9: the vector table base is fixed at address zero.
// RULE10: word zero is the stack pointer init; word n is vector n's entry.
// RULE11: write one sets or clears enables; both locations read the enable state.
// RULE12: disabled inputs still become pending but never activate.
// RULE13: clearing an enable leaves an active interrupt active until its return.
// RULE14: write one sets or clears pending; both locations read pending state.
// RULE15: clearing pending never changes the active state.
// RULE16: each priority is an 8-bit field, four to a 32-bit word.
// RULE17: 32 interrupt inputs, each with one of four priority levels.
// RULE18: a wrap with tick interrupt enabled raises the tick exception request.
// RULE19: lowest priority value wins among pending enabled; ties go to lower number.
module cit_core
	import cit_pkg::*;
#(
	parameter int NUM_IRQ  = 32,
	parameter int TICK_DIV = 1
) (
	// Clock and reset.
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	// AXI4-Lite write channels.
	input  wire logic [7:0]           s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	// AXI4-Lite read channels.
	input  wire logic [7:0]           s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	// Peripheral interrupt lines.
	input  wire logic [NUM_IRQ-1:0]   irq_i,
	// Core side.
	output cit_req_t                  irq_req_o,
	input  wire logic                 irq_ack_i,
	input  wire logic                 irq_ret_i,
	input  wire logic [4:0]           irq_ret_num_i,
	output logic                      tick_req_o,
	input  wire logic                 tick_ack_i,
	output logic [31:0]               sp_init_addr_o
);

	// ************************************************************
	// Functions.
	// ************************************************************

	// Merges written bytes into an old word under the byte strobes.
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	// Expands byte strobes into a bit mask.
	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		return strb_merge(ZERO_WORD, 32'hFFFF_FFFF, strb);
	endfunction : strb_mask

	// Handler entry address for an exception number.
	function automatic logic [31:0] vec_addr(input logic [EXC_NUM_W-1:0] n);
		return VECTOR_BASE + {24'h00_0000, n, 2'h0};
	endfunction : vec_addr

	// ************************************************************
	// State.
	// ************************************************************
	logic [NUM_IRQ-1:0]      en_r;
	logic [NUM_IRQ-1:0]      pend_r;
	logic [NUM_IRQ-1:0]      active_r;
	logic [PRIO_IMPL_W-1:0]  prio_r [NUM_IRQ];
	logic                    tick_en_r;
	logic                    tick_int_r;
	logic                    tick_flag_r;
	logic                    tick_pend_r;
	logic [TICK_W-1:0]       tick_cur_r;
	logic [TICK_W-1:0]       tick_reload_r;
	logic [15:0]             div_cnt_r;
	logic                    aw_hold_r;
	logic                    w_hold_r;
	logic [7:0]              awaddr_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;
	logic                    bvalid_r;
	logic [1:0]              bresp_r;
	logic                    rvalid_r;
	logic [31:0]             rdata_r;
	logic [1:0]              rresp_r;
	cit_req_t                req_r;

	logic                    do_write;
	logic                    ar_hs;
	logic                    tick_pulse;
	logic                    tick_wrap;
	logic [31:0]             wmask;
	logic [NUM_IRQ-1:0]      ack_mask;
	cit_req_t                req_nxt;

	// ************************************************************
	// AXI4-Lite slave.
	// ************************************************************

	// Address and data are taken independently; one write in flight.
	assign s_axi_awready_o = !aw_hold_r;
	assign s_axi_wready_o  = !w_hold_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = !rvalid_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign ar_hs    = s_axi_arvalid_i && !rvalid_r;
	assign wmask    = strb_mask(wstrb_r);

	// Write address, data and response holding.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= ZERO_WORD;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && !aw_hold_r) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && !w_hold_r) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (awaddr_r[1:0] != 2'h0 ||
					awaddr_r == IRQ_ACTIVE_OFS ||
					(awaddr_r > TICK_CURRENT_OFS &&
					 awaddr_r < IRQ_SET_EN_OFS) ||
					(awaddr_r > IRQ_ACTIVE_OFS &&
					 awaddr_r < IRQ_PRIO_OFS) ||
					awaddr_r > IRQ_PRIO_LAST) ?
					RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read data mux, registered on the address handshake.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= ZERO_WORD;
			rresp_r  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= ZERO_WORD;
			unique case (s_axi_araddr_i)
				TICK_CTRL_OFS: begin
					rdata_r[CTRL_EN_BIT]   <= tick_en_r;
					rdata_r[CTRL_INT_BIT]  <= tick_int_r;
					rdata_r[CTRL_FLAG_BIT] <= tick_flag_r;
				end
				TICK_RELOAD_OFS:  rdata_r[TICK_W-1:0] <= tick_reload_r;
				TICK_CURRENT_OFS: rdata_r[TICK_W-1:0] <= tick_cur_r;
				// RULE11: enable read back
				IRQ_SET_EN_OFS, IRQ_CLR_EN_OFS: rdata_r <= 32'(en_r);
				// RULE14: pending read back
				IRQ_SET_PEND_OFS, IRQ_CLR_PEND_OFS: rdata_r <= 32'(pend_r);
				IRQ_ACTIVE_OFS:   rdata_r <= 32'(active_r);
				default: begin
					if (s_axi_araddr_i >= IRQ_PRIO_OFS &&
						s_axi_araddr_i <= IRQ_PRIO_LAST &&
						s_axi_araddr_i[1:0] == 2'h0) begin
						// RULE16: four 8-bit fields, top bits held
						for (int k = 0; k < PRIO_PER_REG; k++) begin
							rdata_r[k*PRIO_FIELD_W +
								PRIO_FIELD_W-PRIO_IMPL_W +: PRIO_IMPL_W] <=
								prio_r[(s_axi_araddr_i[4:2])*PRIO_PER_REG
								+ k];
						end
					end else begin
						rresp_r <= RESP_SLVERR;
					end
				end
			endcase
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	// ************************************************************
	// Tick timer.
	// ************************************************************

	// Divider making the tick rate enable pulse.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_r <= 16'h0000;
		end else if (div_cnt_r >= 16'(TICK_DIV - 1)) begin
			div_cnt_r <= 16'h0000;
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
		end
	end
	assign tick_pulse = tick_en_r && (div_cnt_r >= 16'(TICK_DIV - 1));
	// RULE3: step from one down to zero
	assign tick_wrap  = tick_pulse && (tick_cur_r == 24'h00_0001);

	// Control bits written by software.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_en_r     <= 1'b0;
			tick_int_r    <= 1'b0;
			tick_reload_r <= TICK_RST;
		end else if (do_write) begin
			if (awaddr_r == TICK_CTRL_OFS && wstrb_r[0]) begin
				tick_en_r  <= wdata_r[CTRL_EN_BIT];
				tick_int_r <= wdata_r[CTRL_INT_BIT];
			end
			if (awaddr_r == TICK_RELOAD_OFS) begin
				tick_reload_r <= TICK_W'(strb_merge(32'(tick_reload_r),
					wdata_r, wstrb_r));
			end
		end
	end

	// Counter proper; a write clears it whatever the data.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cur_r <= TICK_RST;
		end else if (do_write && awaddr_r == TICK_CURRENT_OFS) begin
			// RULE5: write clears counter
			tick_cur_r <= TICK_RST;
		end else if (tick_pulse) begin
			if (tick_cur_r == TICK_RST) begin
				// RULE2: reload after zero
				// RULE7: zero reload holds zero
				// RULE6: cleared counter starts from reload
				tick_cur_r <= tick_reload_r;
			end else begin
				// RULE1: 24-bit down count
				tick_cur_r <= tick_cur_r - 24'h00_0001;
			end
		end
	end

	// Wrap flag; a wrap in the same cycle as the clearing read wins.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_flag_r <= 1'b0;
		end else if (tick_wrap) begin
			// RULE3: set on wrap
			tick_flag_r <= 1'b1;
		end else if ((ar_hs && s_axi_araddr_i == TICK_CTRL_OFS) ||
			(do_write && awaddr_r == TICK_CURRENT_OFS)) begin
			// RULE4: read clears flag
			tick_flag_r <= 1'b0;
		end
	end

	// Tick exception request held until the core takes it.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_pend_r <= 1'b0;
		end else if (tick_wrap && tick_int_r) begin
			// RULE18: raise tick exception
			tick_pend_r <= 1'b1;
		end else if (tick_ack_i) begin
			tick_pend_r <= 1'b0;
		end
	end
	assign tick_req_o = tick_pend_r;

	// ************************************************************
	// Interrupt controller.
	// ************************************************************

	// One-hot of the request the core takes this cycle.
	assign ack_mask = (irq_ack_i && req_r.valid) ?
		(NUM_IRQ'(1) << req_r.irq) : '0;

	// Enable bits, write one to set or clear.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_r <= '0;
		end else if (do_write) begin
			// RULE11: write-one set and clear
			if (awaddr_r == IRQ_SET_EN_OFS) begin
				en_r <= en_r | NUM_IRQ'(wdata_r & wmask);
			end else if (awaddr_r == IRQ_CLR_EN_OFS) begin
				en_r <= en_r & ~NUM_IRQ'(wdata_r & wmask);
			end
		end
	end

	// Pending bits; input assertion and set win over any clear.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_r <= '0;
		end else begin
			// RULE12: pend regardless of enable
			// RULE14: write-one set and clear
			pend_r <= (pend_r & ~ack_mask &
				~((do_write && awaddr_r == IRQ_CLR_PEND_OFS) ?
				NUM_IRQ'(wdata_r & wmask) : '0)) | irq_i |
				((do_write && awaddr_r == IRQ_SET_PEND_OFS) ?
				NUM_IRQ'(wdata_r & wmask) : '0);
		end
	end

	// Active bits, cleared only by reset or exception return.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_r <= '0;
		end else begin
			// RULE13: disable leaves active
			// RULE15: clear-pending leaves active
			active_r <= (active_r & ~(irq_ret_i ?
				(NUM_IRQ'(1) << irq_ret_num_i) : '0)) | ack_mask;
		end
	end

	// Priority fields, two levels bits kept per 8-bit field.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_IRQ; i++) begin
				prio_r[i] <= '0;
			end
		end else if (do_write && awaddr_r >= IRQ_PRIO_OFS &&
			awaddr_r <= IRQ_PRIO_LAST && awaddr_r[1:0] == 2'h0) begin
			// RULE17: four levels per input
			for (int k = 0; k < PRIO_PER_REG; k++) begin
				if (wstrb_r[k]) begin
					prio_r[(awaddr_r[4:2])*PRIO_PER_REG + k] <=
						wdata_r[k*PRIO_FIELD_W + PRIO_FIELD_W -
						PRIO_IMPL_W +: PRIO_IMPL_W];
				end
			end
		end
	end

	// Selects the winning candidate among pending enabled idle inputs.
	always_comb begin
		logic [NUM_IRQ-1:0] cand;
		cand    = pend_r & en_r & ~active_r & ~ack_mask;
		req_nxt = '0;
		// RULE19: lowest value, then lowest number
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (cand[i] && (!req_nxt.valid || prio_r[i] < req_nxt.prio)) begin
				req_nxt.valid = 1'b1;
				req_nxt.irq   = 5'(i);
				req_nxt.prio  = prio_r[i];
			end
		end
		req_nxt.exc_num = IRQ_EXC_BASE + EXC_NUM_W'(req_nxt.irq);
		// RULE8: entry from vector table
		req_nxt.vector_addr = vec_addr(req_nxt.exc_num);
	end

	// Request register seen by the core.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end
	assign irq_req_o = req_r;

	// RULE9: fixed base at zero
	// RULE10: word zero holds stack init
	assign sp_init_addr_o = VECTOR_BASE;

endmodule : cit_core

// ### tb/cit_core_asserts.sv
// Port checker of the interrupt controller and tick timer.
// Assumes it is bound to cit_core and sees only that module's ports.
`timescale 1ns/1ps
// ****************************************
// Port checker.
// ****************************************
module cit_core_asserts
	import cit_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Register bus.
	input  wire logic        s_axi_awvalid_i,
	input  wire logic        s_axi_awready_o,
	input  wire logic        s_axi_wvalid_i,
	input  wire logic        s_axi_wready_o,
	input  wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_arvalid_i,
	input  wire logic        s_axi_arready_o,
	input  wire logic [31:0] s_axi_rdata_o,
	input  wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Core side.
	input  wire cit_req_t    irq_req_o,
	input  wire logic        irq_ack_i,
	input  wire logic        tick_req_o,
	input  wire logic        tick_ack_i,
	input  wire logic [31:0] sp_init_addr_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// The stack word address never leaves the table base.
	property p_sp; sp_init_addr_o == VECTOR_BASE; endproperty
	a_sp: assert property (p_sp)
		else $error("stack init address moved");
	// A presented request points at its own table word.
	property p_vec;
		irq_req_o.valid |-> irq_req_o.vector_addr ==
			VECTOR_BASE + {24'h0, irq_req_o.exc_num, 2'b00};
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector address wrong");
	// The exception number follows the input number.
	property p_exc;
		irq_req_o.valid |-> irq_req_o.exc_num ==
			IRQ_EXC_BASE + {1'b0, irq_req_o.irq};
	endproperty
	a_exc: assert property (p_exc)
		else $error("exception number wrong");
	// An accepted input is active and is not offered again.
	property p_act;
		irq_ack_i && irq_req_o.valid |=> !(irq_req_o.valid &&
			irq_req_o.irq == $past(irq_req_o.irq));
	endproperty
	a_act: assert property (p_act)
		else $error("active input offered again");
	// The tick request stands until the core takes it.
	property p_tick; tick_req_o && !tick_ack_i |=> tick_req_o; endproperty
	a_tick: assert property (p_tick)
		else $error("tick request dropped");
	// A taken read answers on the next cycle.
	property p_rd;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read answer late");
	// Read data hold while the master stalls.
	property p_rhold;
		s_axi_rvalid_o && !s_axi_rready_i |=>
			s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data changed while stalled");
	// A write taken on both channels answers two edges later.
	property p_wr;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
			s_axi_wready_o |-> ##2 s_axi_bvalid_o;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write answer timing wrong");
endmodule : cit_core_asserts

bind cit_core cit_core_asserts cit_core_asserts_i (.*);

// ### tb/cit_core_model.sv
// Behavioural model of the processor core that takes the requests.
// Assumes the controller's request struct and one clock domain.
`timescale 1ns/1ps
// ****************************************
// Core model.
// ****************************************
module cit_core_model
	import cit_pkg::*;
(
	// Clock and reset.
	input  wire logic  sys_clk_i,
	input  wire logic  rst_i,
	// Commands from the bench.
	input  wire logic  ack_en_i,
	input  wire logic  ret_en_i,
	input  wire logic  slow_i,
	// Controller side.
	input  wire cit_req_t irq_req_i,
	input  wire logic  tick_req_i,
	output logic       irq_ack_o,
	output logic       irq_ret_o,
	output logic [4:0] irq_ret_num_o,
	output logic       tick_ack_o
);
	logic [4:0] stk[$];
	logic [1:0] wait_r;

	// Takes offered requests, promptly or after a stall, then returns them.
	// return ends active
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_ack_o <= 1'b0;
			irq_ret_o <= 1'b0;
			irq_ret_num_o <= 5'h00;
			wait_r <= 2'h0;
			stk.delete();
		end else begin
			irq_ack_o <= 1'b0;
			irq_ret_o <= 1'b0;
			irq_ret_num_o <= ~irq_ret_num_o; // Stale number never lingers.
			if (irq_req_i.valid && ack_en_i && !irq_ack_o) begin
				if (slow_i && wait_r != 2'h3) begin
					wait_r <= wait_r + 2'h1;
				end else begin
					irq_ack_o <= 1'b1;
					wait_r <= 2'h0;
					stk.push_back(irq_req_i.irq);
				end
			end else if (ret_en_i && stk.size() != 0 && !irq_ret_o) begin
				irq_ret_o <= 1'b1;
				irq_ret_num_o <= stk.pop_back();
			end
		end
	end

	// Takes each tick request one cycle after it shows.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_ack_o <= 1'b0;
		end else begin
			tick_ack_o <= tick_req_i && !tick_ack_o;
		end
	end
endmodule : cit_core_model

// ### tb/cit_core_test.sv
// Self-checking bench of the interrupt controller and tick timer.
// Assumes the core model and the bound port checker are compiled.
`timescale 1ns/1ps
// ****************************************
// Bench.
// ****************************************
module cit_core_test;
	import cit_pkg::*;

	logic        clk = 1'b0, rst = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, irq = 32'h0, rdata, sp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	cit_req_t    req;
	logic        ack, ret, tick_req, tick_ack;
	logic        ack_en = 1'b0, ret_en = 1'b0, slow = 1'b0, tr_prev;
	logic [4:0]  ret_num;
	int          miscompares = 0, tests_run = 0;
	int          cyc = 0, rises = 0, last_rise = 0, gap = 0;

	always #2 clk = ~clk;

	cit_core #(.NUM_IRQ(32), .TICK_DIV(1)) cit_core_i (.sys_clk_i(clk),
		.rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .irq_i(irq), .irq_req_o(req),
		.irq_ack_i(ack), .irq_ret_i(ret), .irq_ret_num_i(ret_num),
		.tick_req_o(tick_req), .tick_ack_i(tick_ack), .sp_init_addr_o(sp));

	cit_core_model cit_core_model_i (.sys_clk_i(clk), .rst_i(rst),
		.ack_en_i(ack_en), .ret_en_i(ret_en), .slow_i(slow),
		.irq_req_i(req), .tick_req_i(tick_req), .irq_ack_o(ack),
		.irq_ret_o(ret), .irq_ret_num_o(ret_num), .tick_ack_o(tick_ack));

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// Compares one value and reports a mismatch.
	task automatic ck(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : ck

	// One write, address and data offered together.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	// One read; data and response come back packed.
	task automatic rd(input logic [7:0] a, output logic [33:0] d);
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = {rresp, rdata};
		rready <= 1'b0;
	endtask : rd

	// Reads until the expected value shows, a bounded number of times.
	task automatic poll(input logic [7:0] a, input logic [31:0] e);
		logic [33:0] d;
		int n;
		n = 0;
		do begin rd(a, d); n++; end while (d[31:0] !== e && n < 20);
		ck(d, {2'b00, e});
	endtask : poll

	// Winner of two pending inputs: lower level, then lower number.
	function automatic logic [4:0] win(int a, int b, logic [1:0] pa,
		logic [1:0] pb);
		if (pa != pb) return (pa < pb) ? 5'(a) : 5'(b);
		return (a < b) ? 5'(a) : 5'(b);
	endfunction : win

	// Cycle count, hang limit and tick request edge timing.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tr_prev <= tick_req;
		if (tick_req && !tr_prev && !rst) begin
			gap <= cyc - last_rise;
			last_rise <= cyc;
			rises <= rises + 1;
		end
		if (cyc == 30000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		logic [33:0] d;
		logic [31:0] m, c;
		logic [1:0]  p[32];
		int a, b, rl, n;
		void'($urandom(73785));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(TICK_CTRL_OFS, d); ck(d, 34'h0);
		rd(8'hFC, d); ck(d[33:32], RESP_SLVERR);
		wr(IRQ_ACTIVE_OFS, 32'hFFFF_FFFF); ck(bresp, RESP_SLVERR);
		// Enable and pending masks, write one sets or clears.
		for (int k = 0; k < 2; k++) begin
			m = $urandom; c = $urandom;
			wr(IRQ_SET_EN_OFS + 8'(8 * k), m);
			wr(IRQ_CLR_EN_OFS + 8'(8 * k), c);
			wr(IRQ_SET_EN_OFS + 8'(8 * k), 32'h0);
			rd(IRQ_SET_EN_OFS + 8'(8 * k), d); ck(d, m & ~c);
			rd(IRQ_CLR_EN_OFS + 8'(8 * k), d); ck(d, m & ~c);
			wr(IRQ_CLR_EN_OFS + 8'(8 * k), 32'hFFFF_FFFF);
		end
		// Priority fields, eight words of four inputs.
		for (int k = 0; k < 8; k++) begin
			m = $urandom;
			wr(IRQ_PRIO_OFS + 8'(4 * k), m);
			rd(IRQ_PRIO_OFS + 8'(4 * k), d); ck(d, m & 32'hC0C0_C0C0);
		end
		// Two sources race; first round is a priority tie.
		for (int k = 0; k < 4; k++) begin
			a = $urandom_range(31);
			b = (a + 1 + $urandom_range(30)) % 32;
			for (int i = 0; i < 32; i++) p[i] = 2'($urandom);
			if (k == 0) p[b] = p[a];
			for (int i = 0; i < 8; i++)
				wr(IRQ_PRIO_OFS + 8'(4 * i), {p[4*i+3], 6'h0, p[4*i+2],
					6'h0, p[4*i+1], 6'h0, p[4*i], 6'h0});
			irq[a] <= 1'b1;
			@(posedge clk);
			irq[a] <= 1'b0;
			wr(IRQ_SET_PEND_OFS, 32'h1 << b);
			m = (32'h1 << a) | (32'h1 << b);
			rd(IRQ_SET_PEND_OFS, d); ck(d, m);
			ck(req.valid, 1'b0);
			wr(IRQ_SET_EN_OFS, m);
			repeat (3) @(posedge clk);
			ck({req.valid, req.irq}, {1'b1, win(a, b, p[a], p[b])});
			slow <= k[0];
			ack_en <= 1'b1;
			poll(IRQ_ACTIVE_OFS, m);
			rd(IRQ_CLR_PEND_OFS, d); ck(d, 34'h0);
			wr(IRQ_CLR_EN_OFS, m);
			wr(IRQ_CLR_PEND_OFS, 32'hFFFF_FFFF);
			rd(IRQ_ACTIVE_OFS, d); ck(d, m);
			ret_en <= 1'b1;
			poll(IRQ_ACTIVE_OFS, 32'h0);
			ack_en <= 1'b0;
			ret_en <= 1'b0;
		end
		// Tick timer: clear, reload, run, period and flag.
		wr(TICK_CURRENT_OFS, $urandom);
		rd(TICK_CURRENT_OFS, d); ck(d, 34'h0);
		rl = $urandom_range(20, 6);
		wr(TICK_RELOAD_OFS, rl);
		wr(TICK_CURRENT_OFS, 32'h0);
		wr(TICK_CTRL_OFS, 32'h3);
		n = 0;
		while (rises < 4 && n < 200) begin @(posedge clk); n++; end
		ck(gap, rl + 1);
		wr(TICK_CTRL_OFS, 32'h2);
		rd(TICK_CURRENT_OFS, d); ck(d <= rl, 1'b1);
		rd(TICK_CTRL_OFS, d); ck(d[16], 1'b1);
		rd(TICK_CTRL_OFS, d); ck(d[16], 1'b0);
		// Zero reload parks the counter at zero.
		wr(TICK_RELOAD_OFS, 32'h0);
		wr(TICK_CURRENT_OFS, $urandom);
		wr(TICK_CTRL_OFS, 32'h3);
		n = rises;
		repeat (30) @(posedge clk);
		rd(TICK_CURRENT_OFS, d); ck(d, 34'h0);
		rd(TICK_CTRL_OFS, d); ck({d[16], rises}, {1'b0, n});
		test_done();
	end
endmodule : cit_core_test
